// *** hw/spp_regs.svh ***
`ifndef SPP_REGS_SVH
`define SPP_REGS_SVH
// ==========================================
// register indexes (byte address is four times the index)
`define SPP_IDX_SEP_THR 6'h11
`define SPP_IDX_VS_CTRL 6'h14
`define SPP_IDX_SLICER 6'h1D
`define SPP_IDX_PWR 6'h1E
`define SPP_IDX_SRC_SEL 6'h1F
`define SPP_IDX_HS_CTRL 6'h20
`define SPP_IDX_WINDOW 6'h23
`define SPP_IDX_DETECT 6'h24
`define SPP_IDX_STATUS 6'h25
// ==========================================
// field positions
`define SPP_VS_FILT_EN 2
`define SPP_SLICER_LSB 3
`define SPP_PWR_AUTO 4
`define SPP_PWR_SW_PD 3
`define SPP_PWR_PIN_POL 2
`define SPP_PWR_OUT_HIZ 1
`define SPP_PWR_SOG_HIZ 0
`define SPP_HS_PLL_FILT 2
`define SPP_HS_PROC_REGEN 1
`define SPP_SRC_LINE_SEL 0
`define SPP_SRC_SEP_LINE 1
`define SPP_ST_EXTRA 1
// ==========================================
// reset values
`define SPP_RST_SEP_THR 8'h20
`define SPP_RST_VS_CTRL 8'h04
`define SPP_RST_SLICER 8'h78
`define SPP_RST_PWR 8'h04
`define SPP_RST_SRC_SEL 8'h00
`define SPP_RST_HS_CTRL 8'h06
`define SPP_RST_WINDOW 8'h0A
// ==========================================
// timing
`define SPP_CLK_NS 10
`define SPP_SEP_UNIT_NS 200
`define SPP_WIN_UNIT_NS 25
`endif

// *** hw/spp_pkg.sv ***
package spp_pkg;
    // apb request bundle from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } spp_apb_req_t;
    // vertical sync filter states
    typedef enum {SPP_VF_IDLE, SPP_VF_WAIT_ON, SPP_VF_ACTIVE, SPP_VF_WAIT_OFF} spp_vf_state_t;
endpackage

// *** hw/spp_sync_power.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "spp_regs.svh"
module spp_sync_power #(
    parameter int DATA_W = 30,
    parameter int PIPE_DEPTH = 6,
    parameter int LINE_W = 16,
    parameter int REGEN_W = 8
) (
    input wire logic pclk, // bus and logic clock
    input wire logic presetn, // async reset
    input wire spp_pkg::spp_apb_req_t apb_req, // apb request
    output logic pready, // apb ready
    output logic [31:0] prdata, // apb read data
    output logic pslverr, // apb error
    input wire logic green_channel_sync_input, // comparator result
    input wire logic [1:0] line_sync_inputs, // line sync inputs
    input wire logic [7:0] sync_detect, // activity detect bits
    input wire logic pwr_pin, // power-down pin
    input wire logic [DATA_W-1:0] data_in, // converter data
    output logic [4:0] slicer_level, // trigger level
    output logic sliced_green_sync_output, // sliced sync pin
    output logic sliced_green_sync_output_oe_n, // low drives
    output logic vsync_out, // cleaned vertical sync
    output logic field_odd, // odd/even field
    output logic pll_sync, // sync to clock loop
    output logic proc_sync, // sync to processing
    output logic power_down, // core powered down
    output logic [DATA_W-1:0] data_out, // output data
    output logic data_oe_n, // low drives data and clock
    output logic data_clk, // output data clock
    output logic data_valid // pipeline filled
);
    localparam int SEP_CYC = `SPP_SEP_UNIT_NS / `SPP_CLK_NS;
    localparam int WIN_CYC_F = `SPP_WIN_UNIT_NS / `SPP_CLK_NS;
    localparam int WIN_CYC = (WIN_CYC_F < 1) ? 1 : WIN_CYC_F;
    localparam int FILL_W = $clog2(PIPE_DEPTH + 1);

    initial begin
        if (DATA_W < 1 || PIPE_DEPTH < 1 || LINE_W < 10 || REGEN_W < 1 || REGEN_W >= 256)
            $error("spp_sync_power: unsupported parameters");
    end

    // ==========================================
    // register bus
    logic [7:0] thr_r, vsc_r, slc_r, pwr_r, src_r, hsc_r, win_r, det_r;
    logic ext_r, pready_r, pslverr_r;
    logic [31:0] prdata_r;
    logic [5:0] idx;
    logic acc, wr_en, rd_en;

    // index from byte address
    function automatic logic [5:0] reg_idx(input logic [7:0] a);
        return a[7:2];
    endfunction

    // decode a mapped register index
    function automatic logic reg_hit(input logic [5:0] i);
        return i inside {`SPP_IDX_SEP_THR, `SPP_IDX_VS_CTRL, `SPP_IDX_SLICER, `SPP_IDX_PWR,
            `SPP_IDX_SRC_SEL, `SPP_IDX_HS_CTRL, `SPP_IDX_WINDOW, `SPP_IDX_DETECT,
            `SPP_IDX_STATUS};
    endfunction

    assign idx = reg_idx(apb_req.paddr);
    assign acc = apb_req.psel & apb_req.penable & pready_r;
    assign wr_en = acc & apb_req.pwrite & reg_hit(idx);
    assign rd_en = acc & ~apb_req.pwrite & reg_hit(idx);

    // no wait state: ready and data in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= apb_req.psel & ~apb_req.penable & ~pready_r;
            pslverr_r <= apb_req.psel & ~apb_req.penable & ~pready_r & ~reg_hit(idx);
            prdata_r <= 32'h0000_0000;
            if (apb_req.psel & ~apb_req.penable & ~apb_req.pwrite) begin
                unique case (idx)
                    `SPP_IDX_SEP_THR: prdata_r <= {24'h000000, thr_r};
                    `SPP_IDX_VS_CTRL: prdata_r <= {24'h000000, vsc_r};
                    `SPP_IDX_SLICER: prdata_r <= {24'h000000, slc_r};
                    `SPP_IDX_PWR: prdata_r <= {24'h000000, pwr_r};
                    `SPP_IDX_SRC_SEL: prdata_r <= {24'h000000, src_r};
                    `SPP_IDX_HS_CTRL: prdata_r <= {24'h000000, hsc_r};
                    `SPP_IDX_WINDOW: prdata_r <= {24'h000000, win_r};
                    `SPP_IDX_DETECT: prdata_r <= {24'h000000, det_r};
                    `SPP_IDX_STATUS: prdata_r <= {30'h0000_0000, ext_r, 1'b0};
                    default: prdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    // writable configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thr_r <= `SPP_RST_SEP_THR;
            vsc_r <= `SPP_RST_VS_CTRL;
            slc_r <= `SPP_RST_SLICER;
            pwr_r <= `SPP_RST_PWR;
            src_r <= `SPP_RST_SRC_SEL;
            hsc_r <= `SPP_RST_HS_CTRL;
            win_r <= `SPP_RST_WINDOW;
        end else if (wr_en) begin
            unique case (idx)
                `SPP_IDX_SEP_THR: thr_r <= apb_req.pwdata[7:0];
                `SPP_IDX_VS_CTRL: vsc_r <= apb_req.pwdata[7:0];
                `SPP_IDX_SLICER: slc_r <= apb_req.pwdata[7:0];
                `SPP_IDX_PWR: pwr_r <= apb_req.pwdata[7:0];
                `SPP_IDX_SRC_SEL: src_r <= apb_req.pwdata[7:0];
                `SPP_IDX_HS_CTRL: hsc_r <= apb_req.pwdata[7:0];
                `SPP_IDX_WINDOW: win_r <= apb_req.pwdata[7:0];
                default: ;
            endcase
        end
    end

    // ==========================================
    // free-running time units
    logic [4:0] t200_cnt_r;
    logic [1:0] t25_cnt_r;
    logic t200;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t200_cnt_r <= 5'h00;
            t25_cnt_r <= 2'h0;
        end else begin
            t200_cnt_r <= (t200_cnt_r == 5'(SEP_CYC - 1)) ? 5'h00 : t200_cnt_r + 5'h01;
            t25_cnt_r <= (t25_cnt_r == 2'(WIN_CYC - 1)) ? 2'h0 : t25_cnt_r + 2'h1;
        end
    end
    assign t200 = (t200_cnt_r == 5'(SEP_CYC - 1));

    // ==========================================
    // slicer, source choice, separator
    logic csync_r, raw_hs, sep_vs_r, hs_d_r, hs_rise;
    logic [7:0] sep_cnt_r;

    // detection and slicing run regardless of power-down
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            csync_r <= 1'b0;
            det_r <= 8'h00;
        end else begin
            csync_r <= green_channel_sync_input;
            det_r <= sync_detect;
        end
    end
    assign raw_hs = src_r[`SPP_SRC_SEP_LINE] ? line_sync_inputs[src_r[`SPP_SRC_LINE_SEL]]
        : csync_r;

    // count units of pulse width, pass only once the count reaches threshold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sep_cnt_r <= 8'h00;
            sep_vs_r <= 1'b0;
            hs_d_r <= 1'b0;
        end else begin
            hs_d_r <= raw_hs;
            if (!raw_hs)
                sep_cnt_r <= 8'h00;
            else if (t200 && sep_cnt_r != 8'hFF)
                sep_cnt_r <= sep_cnt_r + 8'h01;
            sep_vs_r <= raw_hs & (sep_cnt_r >= thr_r);
        end
    end
    assign hs_rise = raw_hs & ~hs_d_r;

    // ==========================================
    // line-sync regenerator and window filter
    logic [LINE_W-1:0] lcnt_r, per_r, win, half;
    logic in_win, accept, regen_r, filt_r;

    assign half = per_r >> 1;
    assign win = LINE_W'(32'(win_r) * WIN_CYC);
    assign in_win = (lcnt_r < win) || (LINE_W'(lcnt_r + win) >= per_r);
    assign accept = hs_rise && (lcnt_r >= half);

    // flywheel: early edges ignored, missing edges bridged
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lcnt_r <= '0;
            per_r <= '1;
            regen_r <= 1'b0;
        end else begin
            if (accept) begin
                per_r <= lcnt_r;
                lcnt_r <= '0;
            end else if (lcnt_r >= per_r) begin
                lcnt_r <= '0;
            end else begin
                lcnt_r <= lcnt_r + 1'b1;
            end
            regen_r <= (accept || lcnt_r >= per_r || lcnt_r < LINE_W'(REGEN_W - 1));
        end
    end

    // pass edges inside the window, flag the rest
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt_r <= 1'b0;
            ext_r <= 1'b0;
        end else begin
            if (hs_rise && in_win)
                filt_r <= 1'b1;
            else if (!raw_hs)
                filt_r <= 1'b0;
            if (hs_rise && !in_win)
                ext_r <= 1'b1;
            else if (rd_en && idx == `SPP_IDX_STATUS)
                ext_r <= 1'b0;
        end
    end

    // source choice for clock loop and processing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_sync <= 1'b0;
            proc_sync <= 1'b0;
        end else begin
            pll_sync <= hsc_r[`SPP_HS_PLL_FILT] ? filt_r : raw_hs;
            proc_sync <= hsc_r[`SPP_HS_PROC_REGEN] ? regen_r : raw_hs;
        end
    end

    // ==========================================
    // vertical sync filter
    spp_pkg::spp_vf_state_t vf_r;
    logic sep_d_r, vf_en, at_mid;

    assign vf_en = vsc_r[`SPP_VS_FILT_EN];
    assign at_mid = (lcnt_r == half);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vf_r <= spp_pkg::SPP_VF_IDLE;
            sep_d_r <= 1'b0;
            vsync_out <= 1'b0;
            field_odd <= 1'b0;
        end else begin
            sep_d_r <= sep_vs_r;
            unique case (vf_r)
                spp_pkg::SPP_VF_IDLE: begin
                    if (sep_vs_r && !sep_d_r) begin
                        if (vf_en) begin
                            field_odd <= (lcnt_r < half);
                            vf_r <= spp_pkg::SPP_VF_WAIT_ON;
                        end else begin
                            field_odd <= 1'b0;
                            vsync_out <= 1'b1;
                            vf_r <= spp_pkg::SPP_VF_ACTIVE;
                        end
                    end
                end
                spp_pkg::SPP_VF_WAIT_ON: begin
                    if (at_mid) begin
                        vsync_out <= 1'b1;
                        vf_r <= spp_pkg::SPP_VF_ACTIVE;
                    end
                end
                spp_pkg::SPP_VF_ACTIVE: begin
                    if (!sep_vs_r)
                        vf_r <= vf_en ? spp_pkg::SPP_VF_WAIT_OFF : spp_pkg::SPP_VF_IDLE;
                    if (!sep_vs_r && !vf_en)
                        vsync_out <= 1'b0;
                end
                spp_pkg::SPP_VF_WAIT_OFF: begin
                    if (at_mid) begin
                        vsync_out <= 1'b0;
                        vf_r <= spp_pkg::SPP_VF_IDLE;
                    end
                end
            endcase
        end
    end

    // ==========================================
    // power control and output enables
    logic pd_nxt, pin_act;

    assign pin_act = pwr_r[`SPP_PWR_PIN_POL] ? pwr_pin : ~pwr_pin;
    assign pd_nxt = pwr_r[`SPP_PWR_AUTO] ? ~(det_r[2] | det_r[3] | det_r[6] | det_r[7])
        : (pin_act | pwr_r[`SPP_PWR_SW_PD]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_down <= 1'b0;
            slicer_level <= 5'h00;
            sliced_green_sync_output <= 1'b0;
            sliced_green_sync_output_oe_n <= 1'b1;
            data_oe_n <= 1'b1;
        end else begin
            power_down <= pd_nxt;
            slicer_level <= slc_r[`SPP_SLICER_LSB +: 5];
            sliced_green_sync_output <= csync_r;
            sliced_green_sync_output_oe_n <= pwr_r[`SPP_PWR_SOG_HIZ];
            data_oe_n <= pwr_r[`SPP_PWR_OUT_HIZ] | pd_nxt;
        end
    end

    // ==========================================
    // output pipeline and data clock
    logic [DATA_W-1:0] pipe_r [PIPE_DEPTH];
    logic [FILL_W-1:0] fill_r;
    logic shift;

    assign shift = data_clk; // data moves on the falling side of the data clock

    // clock at half rate, rising midway between data updates
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            data_clk <= 1'b0;
        else
            data_clk <= ~data_clk & ~power_down;
    end

    genvar g;
    generate
        for (g = 0; g < PIPE_DEPTH; g++) begin : g_pipe
            // one stage of the output pipeline
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn)
                    pipe_r[g] <= '0;
                else if (shift)
                    pipe_r[g] <= (g == 0) ? data_in : pipe_r[(g == 0) ? 0 : g - 1];
            end
        end
    endgenerate

    // count data sets until the pipeline has flushed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fill_r <= '0;
            data_valid <= 1'b0;
            data_out <= '0;
        end else begin
            if (power_down)
                fill_r <= '0;
            else if (shift && fill_r != FILL_W'(PIPE_DEPTH))
                fill_r <= fill_r + 1'b1;
            if (shift) begin
                data_out <= pipe_r[PIPE_DEPTH-1];
                data_valid <= !power_down && fill_r == FILL_W'(PIPE_DEPTH);
            end else if (power_down) begin
                data_valid <= 1'b0;
            end
        end
    end

    assign pready = pready_r;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;

    // ==========================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_vs_request;
        vf_en && vf_r == spp_pkg::SPP_VF_WAIT_ON && at_mid;
    endsequence
    property p_vs_mid;
        s_vs_request |=> vsync_out && vf_r == spp_pkg::SPP_VF_ACTIVE;
    endproperty
    a_vs_mid: assert property (p_vs_mid) else $error("vsync not moved to mid-line");

    property p_sep_short;
        !raw_hs |=> !sep_vs_r;
    endproperty
    a_sep_short: assert property (p_sep_short) else $error("short pulse passed separator");

    property p_sep_thr;
        $rose(sep_vs_r) |-> $past(sep_cnt_r) >= $past(thr_r);
    endproperty
    a_sep_thr: assert property (p_sep_thr) else $error("separator opened before threshold");

    property p_extra;
        hs_rise && !in_win |=> ext_r;
    endproperty
    a_extra: assert property (p_extra) else $error("extraneous pulse not flagged");

    property p_pll_sel;
        hsc_r[`SPP_HS_PLL_FILT] ##1 hsc_r[`SPP_HS_PLL_FILT] |-> pll_sync == $past(filt_r);
    endproperty
    a_pll_sel: assert property (p_pll_sel) else $error("clock loop sync source wrong");

    property p_auto_pwr;
        pwr_r[`SPP_PWR_AUTO] && det_r[6] |=> !power_down;
    endproperty
    a_auto_pwr: assert property (p_auto_pwr) else $error("auto mode powered down with sync");

    property p_man_pwr;
        !pwr_r[`SPP_PWR_AUTO] && pwr_r[`SPP_PWR_SW_PD] |=> power_down ##1 data_oe_n;
    endproperty
    a_man_pwr: assert property (p_man_pwr) else $error("manual power-down ignored");

    property p_sog_hiz;
        $rose(pwr_r[`SPP_PWR_SOG_HIZ]) |=> sliced_green_sync_output_oe_n;
    endproperty
    a_sog_hiz: assert property (p_sog_hiz) else $error("sliced sync output not floated");

    property p_clk_mid;
        $rose(data_clk) |-> $stable(data_out);
    endproperty
    a_clk_mid: assert property (p_clk_mid) else $error("data changed on data clock rise");

    property p_fill;
        $rose(data_valid) |-> $past(fill_r) == FILL_W'(PIPE_DEPTH);
    endproperty
    a_fill: assert property (p_fill) else $error("data valid before pipeline flushed");
endmodule
`default_nettype wire

// *** verif/spp_sync_power_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "spp_regs.svh"
module spp_sync_power_tb_top;
// ==========================================
// signals
logic pclk = 1'b0;
logic presetn = 1'b0;
spp_pkg::spp_apb_req_t apb_req = '0;
logic green = 1'b0;
logic [1:0] line_sync_inputs = 2'b00;
logic [7:0] sync_detect = 8'h00;
logic pwr_pin = 1'b0;
logic [29:0] data_in = 30'h00000000;
logic pready;
logic [31:0] prdata;
logic pslverr;
logic [4:0] slicer_level;
logic sliced;
logic sliced_oe_n;
logic vsync_out;
logic field_odd;
logic pll_sync;
logic proc_sync;
logic power_down;
logic [29:0] data_out;
logic data_oe_n;
logic data_clk;
logic data_valid;
logic [31:0] rd;
logic err;
int fail_count = 0;
int tests_run = 0;
int r;
// 100 MHz clock
always #5 pclk = ~pclk;
spp_sync_power uut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .green_channel_sync_input(green),
    .line_sync_inputs(line_sync_inputs), .sync_detect(sync_detect), .pwr_pin(pwr_pin),
    .data_in(data_in), .slicer_level(slicer_level), .sliced_green_sync_output(sliced),
    .sliced_green_sync_output_oe_n(sliced_oe_n), .vsync_out(vsync_out),
    .field_odd(field_odd), .pll_sync(pll_sync), .proc_sync(proc_sync),
    .power_down(power_down), .data_out(data_out), .data_oe_n(data_oe_n),
    .data_clk(data_clk), .data_valid(data_valid));
// ==========================================
// shared tasks
task results();
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
        $display("All tests passed");
    end else begin
        $display("Some tests failed");
    end
    $finish;
endtask
task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
        fail_count++;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
endtask
task cyc(input int n);
    repeat (n) @(posedge pclk);
endtask
// one apb transfer, waits for pready with a bound
task apb(input logic wr, input logic [5:0] idx, input logic [7:0] d);
    int n;
    @(posedge pclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00},
                 pwdata: {24'h000000, d}};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
        @(posedge pclk);
        n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fail_count++;
    rd = prdata;
    err = pslverr;
    apb_req <= '0;
endtask
task rdchk(input logic [5:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check(rd, {24'h000000, exp});
endtask
// sync pulse on slicer or line input, returns cycle of vsync rise
task pulse(input logic line, input int len, output int rise);
    rise = -1;
    if (line) line_sync_inputs <= 2'b01;
    else green <= 1'b1;
    for (int i = 0; i < len; i++) begin
        @(posedge pclk);
        if (vsync_out === 1'b1 && rise < 0) rise = i;
    end
    line_sync_inputs <= 2'b00;
    green <= 1'b0;
    cyc(6);
    check(vsync_out, 1'b0);
endtask
// ==========================================
// scenarios
task t_regs();
    rdchk(`SPP_IDX_SEP_THR, `SPP_RST_SEP_THR);
    rdchk(`SPP_IDX_VS_CTRL, `SPP_RST_VS_CTRL);
    rdchk(`SPP_IDX_SLICER, `SPP_RST_SLICER);
    rdchk(`SPP_IDX_PWR, `SPP_RST_PWR);
    rdchk(`SPP_IDX_SRC_SEL, `SPP_RST_SRC_SEL);
    rdchk(`SPP_IDX_HS_CTRL, `SPP_RST_HS_CTRL);
    rdchk(`SPP_IDX_WINDOW, `SPP_RST_WINDOW);
    apb(1'b1, `SPP_IDX_WINDOW, 8'h5A);
    rdchk(`SPP_IDX_WINDOW, 8'h5A);
    apb(1'b0, 6'h00, 8'h00);
    check(err, 1'b1);
    check(rd, 32'h00000000);
    sync_detect <= 8'h81;
    apb(1'b1, `SPP_IDX_DETECT, 8'hFF);
    rdchk(`SPP_IDX_DETECT, 8'h81);
    sync_detect <= 8'h00;
endtask
task t_slicer();
    apb(1'b1, `SPP_IDX_SLICER, 8'hA8);
    cyc(2);
    check(slicer_level, 5'h15);
    green <= 1'b1;
    cyc(3);
    check(sliced, 1'b1);
    green <= 1'b0;
    cyc(3);
    check(sliced, 1'b0);
    apb(1'b1, `SPP_IDX_PWR, 8'h05);
    cyc(2);
    check(sliced_oe_n, 1'b1);
    apb(1'b1, `SPP_IDX_PWR, 8'h04);
    cyc(2);
    check(sliced_oe_n, 1'b0);
endtask
task t_power();
    pwr_pin <= 1'b1;
    cyc(3);
    check(power_down, 1'b1);
    apb(1'b1, `SPP_IDX_PWR, 8'h00);
    cyc(3);
    check(power_down, 1'b0);
    pwr_pin <= 1'b0;
    cyc(3);
    check(power_down, 1'b1);
    apb(1'b1, `SPP_IDX_PWR, 8'h0C);
    cyc(3);
    check(power_down, 1'b1);
    green <= 1'b1;
    cyc(3);
    check(sliced, 1'b1);
    green <= 1'b0;
    rdchk(`SPP_IDX_PWR, 8'h0C);
    apb(1'b1, `SPP_IDX_PWR, 8'h10);
    for (int i = 0; i < 8; i++) begin
        sync_detect <= 8'h01 << i;
        cyc(4);
        check(power_down, !(i == 2 || i == 3 || i == 6 || i == 7));
    end
    sync_detect <= 8'h00;
    cyc(4);
    check(power_down, 1'b1);
    apb(1'b1, `SPP_IDX_PWR, 8'h04);
    cyc(3);
    check(power_down, 1'b0);
endtask
task t_data();
    logic [29:0] prev;
    data_in <= 30'h2AAAAAAA;
    cyc(40);
    check(data_valid, 1'b1);
    check(data_out, 30'h2AAAAAAA);
    data_in <= 30'h15555555;
    cyc(6);
    check(data_out, 30'h2AAAAAAA);
    for (int i = 0; i < 12; i++) begin
        prev = data_out;
        cyc(1);
        if (data_out !== prev) check(data_clk, 1'b0);
    end
    check(data_out, 30'h15555555);
    apb(1'b1, `SPP_IDX_PWR, 8'h06);
    cyc(3);
    check(data_oe_n, 1'b1);
    check(power_down, 1'b0);
    apb(1'b1, `SPP_IDX_PWR, 8'h04);
    cyc(3);
    check(data_oe_n, 1'b0);
endtask
task t_sep();
    apb(1'b1, `SPP_IDX_VS_CTRL, 8'h00);
    apb(1'b1, `SPP_IDX_SEP_THR, 8'h02);
    pulse(1'b0, 15, r);
    check(r, 32'hFFFFFFFF);
    pulse(1'b0, 120, r);
    check(r >= 18 && r <= 46, 1'b1);
    check(field_odd, 1'b0);
    apb(1'b1, `SPP_IDX_SRC_SEL, 8'h02);
    pulse(1'b1, 15, r);
    check(r, 32'hFFFFFFFF);
    apb(1'b1, `SPP_IDX_SEP_THR, 8'h04);
    pulse(1'b1, 120, r);
    check(r >= 58 && r <= 86, 1'b1);
endtask
task t_route();
    apb(1'b1, `SPP_IDX_SRC_SEL, 8'h03);
    apb(1'b1, `SPP_IDX_HS_CTRL, 8'h00);
    line_sync_inputs <= 2'b10;
    cyc(4);
    check(pll_sync, 1'b1);
    check(proc_sync, 1'b1);
    line_sync_inputs <= 2'b01;
    cyc(4);
    check(pll_sync, 1'b0);
    check(proc_sync, 1'b0);
    line_sync_inputs <= 2'b00;
    // leave the block in the recommended software setup
    apb(1'b1, `SPP_IDX_HS_CTRL, 8'h06);
    rdchk(`SPP_IDX_HS_CTRL, 8'h06);
    apb(1'b1, `SPP_IDX_VS_CTRL, 8'h04);
    rdchk(`SPP_IDX_VS_CTRL, 8'h04);
endtask
// watchdog
initial begin
    #400000;
    fail_count++;
    results();
end
// main sequence
initial begin
    cyc(10);
    presetn <= 1'b1;
    t_regs();
    t_slicer();
    t_power();
    t_data();
    t_sep();
    t_route();
    results();
end
endmodule
`default_nettype wire
